// ### logic/rtd_pkg.sv
// Constants shared by the ring trip detector design files.
package rtd_pkg;

    // Clock rate and the one millisecond processing tick.
    localparam int unsigned CLK_FREQ_KHZ   = 20_000;
    localparam int unsigned TICK_TIME_MS   = 1;
    localparam int unsigned TICK_CYCLES    = CLK_FREQ_KHZ * TICK_TIME_MS;
    localparam int unsigned TICK_CNT_W     = 15;

    // Length of the current limit boost after ringing ends, in ticks.
    localparam int unsigned BOOST_TIME_MS  = 8;
    localparam logic [3:0]  BOOST_TICKS    = 4'(BOOST_TIME_MS / TICK_TIME_MS);

    // Direct register offsets.
    localparam logic [7:0] ADDR_IRQ_PEND   = 8'h13;
    localparam logic [7:0] ADDR_IRQ_CLR    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN     = 8'h16;
    localparam logic [7:0] ADDR_IND_DLO    = 8'h1c;
    localparam logic [7:0] ADDR_IND_DHI    = 8'h1d;
    localparam logic [7:0] ADDR_IND_WADDR  = 8'h1e;
    localparam logic [7:0] ADDR_IND_RADDR  = 8'h1f;
    localparam logic [7:0] ADDR_LINEFEED   = 8'h40;
    localparam logic [7:0] ADDR_STATUS     = 8'h44;
    localparam logic [7:0] ADDR_DEBOUNCE   = 8'h46;
    localparam logic [7:0] ADDR_HIGH_BATT  = 8'h4a;
    localparam logic [7:0] ADDR_LOOP_CUR   = 8'h4f;
    localparam logic [7:0] ADDR_BOOST_CTRL = 8'h6c;

    // Indirect register offsets.
    localparam logic [7:0] IND_THRESHOLD   = 8'h1d;
    localparam logic [7:0] IND_FILT_COEFF  = 8'h24;
    localparam logic [7:0] IND_HEADROOM    = 8'h28;

    // Field positions.
    localparam int unsigned TRIP_IRQ_BIT   = 0;
    localparam int unsigned TRIP_STAT_BIT  = 0;
    localparam int unsigned BOOST_EN_BIT   = 7;
    localparam int unsigned LF_SHADOW_LSB  = 4;

    // Linefeed code of the ringing state.
    localparam logic [2:0] LF_RINGING      = 3'b100;

    // Values after reset.
    localparam logic [2:0]  LF_RESET       = 3'h0;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [5:0]  HIGH_BATT_RESET = 6'h00;

    // Filter fixed point: coefficient is a fraction of 2^13.
    localparam int unsigned FILT_FRAC_W    = 13;
    localparam int unsigned SAMPLE_W       = 6;

endpackage

// ### logic/rtd_lowpass.sv
// First order low-pass filter for loop current samples.
`timescale 1ns/1ps
module rtd_lowpass (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           step,
    input  wire logic                           clear,
    input  wire logic [rtd_pkg::SAMPLE_W-1:0]   sample,
    input  wire logic [12:0]                    coeff,
    output logic      [rtd_pkg::SAMPLE_W-1:0]   filtered
);
    import rtd_pkg::*;

    localparam int unsigned ACC_W = SAMPLE_W + FILT_FRAC_W;

    logic        [ACC_W-1:0] acc_q;
    logic        [ACC_W-1:0] acc_d;
    logic signed [ACC_W:0]   diff;
    logic signed [ACC_W+14:0] prod;
    logic signed [ACC_W:0]   delta;

    // Each step moves the state toward the sample by coeff/8192 of the gap.
    assign diff     = $signed({1'b0, sample, {FILT_FRAC_W{1'b0}}}) - $signed({1'b0, acc_q});
    assign prod     = diff * $signed({1'b0, coeff});
    assign delta    = (ACC_W + 1)'(prod >>> FILT_FRAC_W);
    assign acc_d    = ACC_W'($signed({1'b0, acc_q}) + delta);
    assign filtered = acc_q[ACC_W-1:FILT_FRAC_W];

    // State register; cleared outside ringing so each ring starts fresh.
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            acc_q <= '0;
        end else if (step) begin
            acc_q <= acc_d;
        end
    end

endmodule

// ### logic/rtd_ring_trip_detector.sv
// Ring trip detector with register port, ringing bias and limit boost.
`timescale 1ns/1ps
// Summary of operation
// - Trip processing runs on loop current samples only while the linefeed shadow shows ringing.
// - Samples pass a low-pass filter with a 13-bit coefficient from an indirect register.
// - Filtered current is compared with a 6-bit indirect threshold feeding the debounce.
// - Debounce output flips only after the opposite level holds for the full interval.
// - A satisfied debounce sets the read-only trip detected status bit.
// - A valid trip raises the interrupt only when its enable bit is set.
// - During ringing the common mode is held at battery minus headroom, floored at zero.
// - Headroom is a 4-bit indirect field at 1.5 V per step below battery.
// - With boost enabled, the current limit rises briefly when ringing ends.
module rtd_ring_trip_detector #(
    parameter int unsigned TickCycles = rtd_pkg::TICK_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic [7:0]                     regAddr,
    input  wire logic [7:0]                     regWrData,
    input  wire logic                           regWr,
    input  wire logic                           regRd,
    output logic      [7:0]                     regRdData,
    input  wire logic [rtd_pkg::SAMPLE_W-1:0]   loopCurrentSample,
    output logic      [2:0]                     linefeedStateField,
    output logic      [5:0]                     ringingCommonMode,
    output logic                                commonModeHold,
    output logic                                currentLimitBoost,
    output logic                                irq
);
    import rtd_pkg::*;

    // True when a linefeed code selects the ringing state.
    function automatic logic isRinging(input logic [2:0] code);
        return code == LF_RINGING;
    endfunction

    // Two-stage synchroniser for the converter sample pins.
    logic [SAMPLE_W-1:0] sampleMeta_q;
    logic [SAMPLE_W-1:0] sampleSync_q;

    // Software visible registers.
    logic [7:0]  irqPend_q;
    logic [7:0]  irqPend_d;
    logic [7:0]  irqEn_q;
    logic [7:0]  indDataLo_q;
    logic [7:0]  indDataHi_q;
    logic [2:0]  linefeed_q;
    logic [2:0]  lfShadow_q;
    logic [6:0]  tripDebounceCount_q;
    logic [5:0]  highBatterySetting_q;
    logic        currentLimitBoostEn_q;
    logic [15:0] tripThreshold_q;
    logic [15:0] tripFilterCoeff_q;
    logic [15:0] ringingHeadroom_q;
    logic [7:0]  regRdData_q;

    // Tick divider and processing state.
    logic [TICK_CNT_W-1:0] tickCnt_q;
    logic                  tick_q;
    logic                  tripDetectedBit_q;
    logic [6:0]            debCnt_q;
    logic                  wasRinging_q;
    logic [3:0]            boostCnt_q;
    logic                  boost_q;
    logic [5:0]            commonMode_q;
    logic                  cmHold_q;
    logic                  irq_q;

    // Decoded strobes and derived values.
    logic                  wrIrqClr;
    logic                  wrIrqEn;
    logic                  wrDataLo;
    logic                  wrDataHi;
    logic                  wrIndWrite;
    logic                  wrIndRead;
    logic                  wrLinefeed;
    logic                  wrDebounce;
    logic                  wrHighBatt;
    logic                  wrBoost;
    logic                  ringing;
    logic                  tickEnd;
    logic [SAMPLE_W-1:0]   filtered;
    logic                  compareHigh;
    logic                  mismatch;
    logic                  debounceDone;
    logic                  tripRise;
    logic                  ringEnd;
    logic [15:0]           indReadValue;
    logic [7:0]            readValue;
    logic [5:0]            cmDiff;

    // Write decode of the direct registers.
    assign wrIrqClr   = regWr && (regAddr == ADDR_IRQ_CLR);
    assign wrIrqEn    = regWr && (regAddr == ADDR_IRQ_EN);
    assign wrDataLo   = regWr && (regAddr == ADDR_IND_DLO);
    assign wrDataHi   = regWr && (regAddr == ADDR_IND_DHI);
    assign wrIndWrite = regWr && (regAddr == ADDR_IND_WADDR);
    assign wrIndRead  = regWr && (regAddr == ADDR_IND_RADDR);
    assign wrLinefeed = regWr && (regAddr == ADDR_LINEFEED);
    assign wrDebounce = regWr && (regAddr == ADDR_DEBOUNCE);
    assign wrHighBatt = regWr && (regAddr == ADDR_HIGH_BATT);
    assign wrBoost    = regWr && (regAddr == ADDR_BOOST_CTRL);

    // Indirect register selected by the data byte of a read command.
    assign indReadValue = (regWrData == IND_THRESHOLD)  ? tripThreshold_q :
                          (regWrData == IND_FILT_COEFF) ? tripFilterCoeff_q :
                          (regWrData == IND_HEADROOM)   ? ringingHeadroom_q : WORD_RESET;

    // Direct register read selection; unmapped addresses read as zero.
    assign readValue =
        (regAddr == ADDR_IRQ_PEND)   ? irqPend_q :
        (regAddr == ADDR_IRQ_EN)     ? irqEn_q :
        (regAddr == ADDR_IND_DLO)    ? indDataLo_q :
        (regAddr == ADDR_IND_DHI)    ? indDataHi_q :
        (regAddr == ADDR_LINEFEED)   ? {1'b0, lfShadow_q, 1'b0, linefeed_q} :
        (regAddr == ADDR_STATUS)     ? 8'(tripDetectedBit_q) << TRIP_STAT_BIT :
        (regAddr == ADDR_DEBOUNCE)   ? {1'b0, tripDebounceCount_q} :
        (regAddr == ADDR_HIGH_BATT)  ? {2'b00, highBatterySetting_q} :
        (regAddr == ADDR_LOOP_CUR)   ? {2'b00, sampleSync_q} :
        (regAddr == ADDR_BOOST_CTRL) ? 8'(currentLimitBoostEn_q) << BOOST_EN_BIT : BYTE_RESET;

    // Processing conditions.
    assign ringing      = isRinging(lfShadow_q);
    assign tickEnd      = (tickCnt_q == TICK_CNT_W'(TickCycles - 1));
    assign compareHigh  = (filtered >= tripThreshold_q[5:0]);
    assign mismatch     = (compareHigh != tripDetectedBit_q);
    assign debounceDone = mismatch && ((debCnt_q + 7'h01) >= tripDebounceCount_q);
    assign tripRise     = ringing && tick_q && debounceDone && !tripDetectedBit_q;
    assign ringEnd      = wasRinging_q && !ringing;

    // Pending flags: a trip sets, a one written to the clear register clears; set wins.
    assign irqPend_d = (irqPend_q & ~(wrIrqClr ? regWrData : BYTE_RESET))
                     | (8'(tripRise) << TRIP_IRQ_BIT);

    // Headroom is subtracted from battery in the same 1.5 V steps, floored at zero.
    assign cmDiff = (highBatterySetting_q > {2'b00, ringingHeadroom_q[3:0]}) ?
                    6'(highBatterySetting_q - {2'b00, ringingHeadroom_q[3:0]}) : 6'h00;

    // Loop current samples cross in from the converter pins.
    always_ff @(posedge clk) begin
        if (rst) begin
            sampleMeta_q <= '0;
            sampleSync_q <= '0;
        end else begin
            sampleMeta_q <= loopCurrentSample;
            sampleSync_q <= sampleMeta_q;
        end
    end

    // One millisecond tick divider.
    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            tickCnt_q <= tickEnd ? '0 : tickCnt_q + 1'b1;
            tick_q    <= tickEnd;
        end
    end

    // Interrupt status, enable and level output.
    always_ff @(posedge clk) begin
        if (rst) begin
            irqPend_q <= BYTE_RESET;
            irqEn_q   <= BYTE_RESET;
            irq_q     <= 1'b0;
        end else begin
            irqPend_q <= irqPend_d;
            if (wrIrqEn) begin
                irqEn_q <= regWrData;
            end
            irq_q <= |(irqPend_d & irqEn_q);
        end
    end

    // Indirect access data bytes: written by software or loaded by a read command.
    always_ff @(posedge clk) begin
        if (rst) begin
            indDataLo_q <= BYTE_RESET;
            indDataHi_q <= BYTE_RESET;
        end else if (wrIndRead) begin
            indDataLo_q <= indReadValue[7:0];
            indDataHi_q <= indReadValue[15:8];
        end else begin
            if (wrDataLo) begin
                indDataLo_q <= regWrData;
            end
            if (wrDataHi) begin
                indDataHi_q <= regWrData;
            end
        end
    end

    // Indirect registers, loaded only by a write command naming their offset.
    always_ff @(posedge clk) begin
        if (rst) begin
            tripThreshold_q   <= WORD_RESET;
            tripFilterCoeff_q <= WORD_RESET;
            ringingHeadroom_q <= WORD_RESET;
        end else if (wrIndWrite) begin
            if (regWrData == IND_THRESHOLD) begin
                tripThreshold_q <= {indDataHi_q, indDataLo_q};
            end
            if (regWrData == IND_FILT_COEFF) begin
                tripFilterCoeff_q <= {indDataHi_q, indDataLo_q};
            end
            if (regWrData == IND_HEADROOM) begin
                ringingHeadroom_q <= {indDataHi_q, indDataLo_q};
            end
        end
    end

    // Direct configuration registers; the shadow follows the control field.
    always_ff @(posedge clk) begin
        if (rst) begin
            linefeed_q            <= LF_RESET;
            lfShadow_q            <= LF_RESET;
            tripDebounceCount_q   <= 7'h00;
            highBatterySetting_q  <= HIGH_BATT_RESET;
            currentLimitBoostEn_q <= 1'b0;
        end else begin
            if (wrLinefeed) begin
                linefeed_q <= regWrData[2:0];
            end
            lfShadow_q <= linefeed_q;
            if (wrDebounce) begin
                tripDebounceCount_q <= regWrData[6:0];
            end
            if (wrHighBatt) begin
                highBatterySetting_q <= regWrData[5:0];
            end
            if (wrBoost) begin
                currentLimitBoostEn_q <= regWrData[BOOST_EN_BIT];
            end
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData_q <= BYTE_RESET;
        end else begin
            regRdData_q <= regRd ? readValue : BYTE_RESET;
        end
    end

    // Loop current filter, stepped once per tick while ringing.
    rtd_lowpass u_lowpass (
        .clk      (clk),
        .rst      (rst),
        .step     (tick_q && ringing),
        .clear    (!ringing),
        .sample   (sampleSync_q),
        .coeff    (tripFilterCoeff_q[12:0]),
        .filtered (filtered)
    );

    // Debounce: count ticks of disagreement, restart on agreement, flip at the interval.
    always_ff @(posedge clk) begin
        if (rst || !ringing) begin
            debCnt_q          <= 7'h00;
            tripDetectedBit_q <= 1'b0;
        end else if (tick_q) begin
            if (!mismatch) begin
                debCnt_q <= 7'h00;
            end else if (debounceDone) begin
                debCnt_q          <= 7'h00;
                tripDetectedBit_q <= compareHigh;
            end else begin
                debCnt_q <= debCnt_q + 7'h01;
            end
        end
    end

    // Ringing bias and the current limit boost when ringing ends.
    always_ff @(posedge clk) begin
        if (rst) begin
            wasRinging_q <= 1'b0;
            boostCnt_q   <= 4'h0;
            boost_q      <= 1'b0;
            commonMode_q <= 6'h00;
            cmHold_q     <= 1'b0;
        end else begin
            wasRinging_q <= ringing;
            cmHold_q     <= ringing;
            commonMode_q <= ringing ? cmDiff : 6'h00;
            if (ringEnd && currentLimitBoostEn_q) begin
                boostCnt_q <= BOOST_TICKS;
                boost_q    <= 1'b1;
            end else if (boost_q && tick_q) begin
                boostCnt_q <= boostCnt_q - 4'h1;
                boost_q    <= (boostCnt_q != 4'h1);
            end
        end
    end

    // Outputs straight from flip-flops.
    assign regRdData          = regRdData_q;
    assign linefeedStateField = lfShadow_q;
    assign ringingCommonMode  = commonMode_q;
    assign commonModeHold     = cmHold_q;
    assign currentLimitBoost  = boost_q;
    assign irq                = irq_q;

endmodule

// ### tb/rtd_trip_checker_assertions.sv
// Concurrent checks on the ports of the ring trip detector.
`timescale 1ns/1ps
module rtd_trip_checker #(
    parameter int unsigned TickCycles = rtd_pkg::TICK_CYCLES
) (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic [7:0]                   regAddr,
    input wire logic [7:0]                   regWrData,
    input wire logic                         regWr,
    input wire logic                         regRd,
    input wire logic [7:0]                   regRdData,
    input wire logic [rtd_pkg::SAMPLE_W-1:0] loopCurrentSample,
    input wire logic [2:0]                   linefeedStateField,
    input wire logic [5:0]                   ringingCommonMode,
    input wire logic                         commonModeHold,
    input wire logic                         currentLimitBoost,
    input wire logic                         irq
);
    import rtd_pkg::*;
    localparam int BoostMax = 8 * TickCycles + 2;
    logic [2:0]  lfWr;
    logic        ringNow;
    logic [31:0] boostLen_q;
    // Decoded views shared by the properties.
    assign lfWr    = regWrData[2:0];
    assign ringNow = (linefeedStateField == LF_RINGING);
    // Counts how long the boost pulse has been high.
    always_ff @(posedge clk) begin
        if (rst || !currentLimitBoost) begin
            boostLen_q <= 32'h0000_0000;
        end else begin
            boostLen_q <= boostLen_q + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_shadow_follow: assert property (
        regWr && regAddr == ADDR_LINEFEED |-> ##2 linefeedStateField == $past(lfWr, 2))
        else $error("linefeed shadow did not follow the write");
    a_hold_ringing: assert property ((ringNow)[*2] |-> commonModeHold)
        else $error("common mode not held while ringing");
    a_hold_idle: assert property ((!ringNow)[*2] |-> !commonModeHold)
        else $error("common mode held outside ringing");
    a_cm_idle_zero: assert property ((!ringNow)[*3] |-> ringingCommonMode == 6'h00)
        else $error("common mode level not zero outside ringing");
    a_irq_masked: assert property (
        regWr && regAddr == ADDR_IRQ_EN && !regWrData[0] |-> ##2 !irq)
        else $error("interrupt high while disabled");
    a_irq_cleared: assert property (
        regWr && regAddr == ADDR_IRQ_CLR && regWrData[0] && !ringNow |-> ##2 !irq)
        else $error("interrupt stayed high after clear");
    a_boost_start: assert property (
        $rose(currentLimitBoost) |-> $past(linefeedStateField, 2) == LF_RINGING && !$past(ringNow))
        else $error("boost began without leaving ringing");
    a_boost_length: assert property (boostLen_q <= BoostMax)
        else $error("boost pulse too long");
    a_status_idle: assert property (
        regRd && regAddr == ADDR_STATUS && !ringNow && !$past(ringNow) |=> regRdData == 8'h00)
        else $error("trip status set outside ringing");
endmodule
bind rtd_ring_trip_detector rtd_trip_checker #(.TickCycles(TickCycles)) chk_i (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .loopCurrentSample(loopCurrentSample), .linefeedStateField(linefeedStateField),
    .ringingCommonMode(ringingCommonMode), .commonModeHold(commonModeHold),
    .currentLimitBoost(currentLimitBoost), .irq(irq));

// ### tb/rtd_sense_model.sv
// Behavioural loop current sense converter that feeds the detector.
`timescale 1ns/1ps
module rtd_sense_model (
    input  wire logic                         clk,
    input  wire logic [rtd_pkg::SAMPLE_W-1:0] level,
    output logic      [rtd_pkg::SAMPLE_W-1:0] sample
);
    import rtd_pkg::*;
    // A new reading appears just after each edge, so all bits change together.
    always_ff @(posedge clk) begin
        sample <= level;
    end
endmodule

// ### tb/rtd_ring_trip_detector_test.sv
// Self-checking testbench for the ring trip detector.
`timescale 1ns/1ps
module rtd_ring_trip_detector_test;
    import rtd_pkg::*;
    localparam int TC = 20;
    logic        clk, rst, regWr, regRd, commonModeHold, currentLimitBoost, irq;
    logic [7:0]  regAddr, regWrData, regRdData, d;
    logic [5:0]  level, sample, ringingCommonMode, b, h, lv, th;
    logic [2:0]  linefeedStateField;
    logic [15:0] w, w2;
    logic [12:0] cf;
    int          num_errors = 0;
    int          n_checks = 0;
    logic [7:0]  ra [8] = '{ADDR_IRQ_PEND, ADDR_IRQ_EN, ADDR_STATUS, ADDR_DEBOUNCE, ADDR_HIGH_BATT,
                            ADDR_BOOST_CTRL, ADDR_LINEFEED, 8'h00};
    logic [7:0]  wa [4] = '{ADDR_DEBOUNCE, ADDR_HIGH_BATT, ADDR_BOOST_CTRL, ADDR_IRQ_EN};
    logic [7:0]  rm [4] = '{8'h7f, 8'h3f, 8'h80, 8'h01};

    rtd_ring_trip_detector #(.TickCycles(TC)) uut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .loopCurrentSample(sample), .linefeedStateField(linefeedStateField),
        .ringingCommonMode(ringingCommonMode), .commonModeHold(commonModeHold),
        .currentLimitBoost(currentLimitBoost), .irq(irq));
    rtd_sense_model model (.clk(clk), .level(level), .sample(sample));

    // Clock of 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Trips only with a moving filter and a current clearly above threshold.
    function automatic logic expTrip(logic [12:0] c, logic [5:0] t, logic [5:0] l);
        return (c != 13'h0000) && (t < l);
    endfunction
    function automatic logic [5:0] expCm(logic [5:0] bb, logic [5:0] hh);
        return (bb > hh) ? bb - hh : 6'h00;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        rd(a, d);
        chk({8'h00, d}, exp);
    endtask
    task automatic iw(input logic [7:0] ia, input logic [15:0] v);
        wr(ADDR_IND_DLO, v[7:0]);
        wr(ADDR_IND_DHI, v[15:8]);
        wr(ADDR_IND_WADDR, ia);
    endtask
    task automatic ir(input logic [7:0] ia, output logic [15:0] v);
        wr(ADDR_IND_RADDR, ia);
        rd(ADDR_IND_DLO, v[7:0]);
        rd(ADDR_IND_DHI, v[15:8]);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog that cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results;
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        {regAddr, regWrData, regWr, regRd, level} = '0;
        w = 16'($urandom(32'hfe6c_86a0));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        waitc(1);
        foreach (ra[i]) rc(ra[i], 16'h0000);
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom) & {8'h00, rm[i]};
            wr(wa[i], w[7:0]);
            rc(wa[i], w);
        end
        wr(ADDR_STATUS, 8'hff);
        rc(ADDR_STATUS, 16'h0000);
        w = 16'($urandom);
        iw(IND_HEADROOM, w);
        ir(IND_HEADROOM, w2);
        chk(w2, w);
        ir(8'h30, w2);
        chk(w2, 16'h0000);
        lv = 6'($urandom);
        level <= lv;
        waitc(4);
        rc(ADDR_LOOP_CUR, {10'h000, lv});
        // A large current outside ringing must not trip.
        iw(IND_FILT_COEFF, 16'h1fff);
        iw(IND_THRESHOLD, 16'h0014);
        wr(ADDR_DEBOUNCE, 8'h01);
        level <= 6'h28;
        wr(ADDR_LINEFEED, 8'h01);
        waitc(6 * TC);
        rc(ADDR_STATUS, 16'h0000);
        rc(ADDR_IRQ_PEND, 16'h0000);
        // Random filter, threshold and current; the first case has a frozen filter.
        for (int i = 0; i < 6; i++) begin
            cf = (i == 0) ? 13'h0000 : 13'h0400 + 13'($urandom % 7168);
            lv = 6'(4 + $urandom % 56);
            th = (i % 2 == 0) ? lv - 6'h02 : lv + 6'h02;
            iw(IND_FILT_COEFF, {3'h0, cf});
            iw(IND_THRESHOLD, {10'h000, th});
            level <= lv;
            wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
            waitc(40 * TC);
            rc(ADDR_STATUS, {15'h0000, expTrip(cf, th, lv)});
            wr(ADDR_LINEFEED, 8'h00);
        end
        // Debounce of three ticks, interrupt, common mode and boost.
        b = 6'($urandom);
        h = 6'($urandom % 16);
        wr(ADDR_HIGH_BATT, {2'h0, b});
        iw(IND_HEADROOM, {12'h000, h[3:0]});
        iw(IND_FILT_COEFF, 16'h1fff);
        iw(IND_THRESHOLD, 16'h0014);
        wr(ADDR_DEBOUNCE, 8'h03);
        wr(ADDR_BOOST_CTRL, 8'h80);
        wr(ADDR_IRQ_EN, 8'h00);
        wr(ADDR_IRQ_CLR, 8'h01);
        level <= 6'h28;
        waitc(4);
        wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
        waitc(2 * TC - 6);
        chk({10'h000, ringingCommonMode}, {10'h000, expCm(b, h)});
        chk({15'h0000, commonModeHold}, 16'h0001);
        chk({13'h0000, linefeedStateField}, {13'h0000, LF_RINGING});
        rc(ADDR_STATUS, 16'h0000);
        waitc(3 * TC);
        rc(ADDR_STATUS, 16'h0001);
        rc(ADDR_IRQ_PEND, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        wr(ADDR_IRQ_EN, 8'h01);
        waitc(2);
        chk({15'h0000, irq}, 16'h0001);
        wr(ADDR_IRQ_CLR, 8'h01);
        waitc(2);
        chk({15'h0000, irq}, 16'h0000);
        level <= 6'h00;
        waitc(5 * TC);
        rc(ADDR_STATUS, 16'h0000);
        rc(ADDR_IRQ_PEND, 16'h0000);
        wr(ADDR_LINEFEED, 8'h00);
        waitc(2);
        chk({15'h0000, currentLimitBoost}, 16'h0001);
        chk({13'h0000, linefeedStateField}, 16'h0000);
        waitc(8 * TC + 4);
        chk({15'h0000, currentLimitBoost}, 16'h0000);
        chk({10'h000, ringingCommonMode}, 16'h0000);
        results;
    end
endmodule
